// >>> ovpseq_pkg.sv
package ovpseq_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned OVPSEQ_CLK_HZ = 25000000;
   localparam int unsigned OVPSEQ_START_MS = 50;
   localparam int unsigned OVPSEQ_BLANK_MS = 50;
   localparam int unsigned OVPSEQ_START_CYC = OVPSEQ_CLK_HZ / 1000 * OVPSEQ_START_MS;
   localparam int unsigned OVPSEQ_BLANK_CYC = OVPSEQ_CLK_HZ / 1000 * OVPSEQ_BLANK_MS;
   localparam int unsigned OVPSEQ_CNT_W = 21;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic OVPSEQ_GATE_RST = 1'b0;
   localparam logic OVPSEQ_FAULT_OE_RST = 1'b1;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      OVPSEQ_ST_LOCKOUT = 2'b00,
      OVPSEQ_ST_DELAY = 2'b01,
      OVPSEQ_ST_STARTUP = 2'b11,
      OVPSEQ_ST_ON = 2'b10
   } ovpseq_state_e;

   typedef struct packed {
      logic low_supply_lockout;
      logic high_supply_lockout;
      logic enable_b;
   } ovpseq_cond_s;

endpackage

// >>> ovpseq_sync.sv
`timescale 1ns/100ps
module ovpseq_sync
   import ovpseq_pkg::*;
#(
   parameter int unsigned WIDTH = 3
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   input wire logic [WIDTH-1:0] rst_val_in,
   output logic [WIDTH-1:0] q_out
);

   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   // Reset value is a tie-off constant from the parent; safe under sync reset
   always_comb begin
      meta_nxt = meta_r;
      q_nxt = q_r;
      if (!rst_b_in) begin
         meta_nxt = rst_val_in;
         q_nxt = rst_val_in;
      end else if (ce_in) begin
         meta_nxt = d_in;
         q_nxt = meta_r;
      end
   end

   always_ff @(posedge clk_in) begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
   end

   assign q_out = q_r;

endmodule

// >>> ovpseq_top.sv
`timescale 1ns/100ps
// What this block does
// R1: Fault indicator is pulled low during any supply lockout and released in normal operation.
// R2: Gate is driven high only while the supply is inside the valid window.
// R3: Enable is active low; the host holds it low and a high level forces the gate off.
// R4: Enable low never turns on the gate or clears the fault during a lockout.
// R5: Low-supply lockout holds the gate low and the fault asserted.
// R6: High-supply lockout holds the gate low and the fault asserted.
// R7: High-supply lockout asserts the fault with no delay or blanking.
// R8: The fault stays low for a 50 ms blanking time after the gate starts to turn on.
// R9: With the supply valid and enable low, a 50 ms delay passes before startup.
// R10: Startup enables the pump and gate, and on blanking expiry the block goes on with fault released.
// R11: At power-up with the supply outside the window, gate is zero and the fault is low.
// R12: Low-supply lockout in any state at once drives the fault low and the gate to ground.
// R13: The fault indicator is open drain, pulled low only when asserted.
// R14: Lockout or enable high during delay or blanking abandons the sequence and restarts the delay.
module ovpseq_top
   import ovpseq_pkg::*;
#(
   parameter int unsigned START_CYC = OVPSEQ_START_CYC,
   parameter int unsigned BLANK_CYC = OVPSEQ_BLANK_CYC
) (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   // Supply comparators and host enable pin
   input wire logic low_supply_lockout_in,
   input wire logic high_supply_lockout_in,
   input wire logic enable_b_in,
   // Charge pump and gate drive
   output logic gate_out,
   // Open-drain fault indicator
   output logic fault_b_out,
   output logic fault_b_oe_out
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   // Both counts share one counter, so each must fit its width
   if (START_CYC < 1 || START_CYC >= (1 << OVPSEQ_CNT_W)) begin : g_bad_start
      $error("START_CYC out of range");
   end
   if (BLANK_CYC < 1 || BLANK_CYC >= (1 << OVPSEQ_CNT_W)) begin : g_bad_blank
      $error("BLANK_CYC out of range");
   end

   localparam logic [OVPSEQ_CNT_W-1:0] START_LAST = OVPSEQ_CNT_W'(START_CYC - 1);
   localparam logic [OVPSEQ_CNT_W-1:0] BLANK_LAST = OVPSEQ_CNT_W'(BLANK_CYC - 1);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   ovpseq_cond_s cond_raw;
   ovpseq_cond_s cond;
   ovpseq_cond_s cond_rst;

   // Comparators out of sync look like a lockout until proven otherwise
   assign cond_raw = '{low_supply_lockout: low_supply_lockout_in,
                       high_supply_lockout: high_supply_lockout_in,
                       enable_b: enable_b_in};
   assign cond_rst = '{low_supply_lockout: 1'b1, high_supply_lockout: 1'b0, enable_b: 1'b1};

   ovpseq_sync #(
      .WIDTH($bits(ovpseq_cond_s))
   ) u_sync (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .ce_in(ce_in),
      .d_in(cond_raw),
      .rst_val_in(cond_rst),
      .q_out(cond)
   );

   // ----------------------------------------
   // Qualification
   // ----------------------------------------
   logic lockout;
   logic qualify;

   // Enable low counts for nothing while either lockout stands
   assign lockout = cond.low_supply_lockout | cond.high_supply_lockout;
   assign qualify = !lockout && !cond.enable_b; // R4

   // ----------------------------------------
   // Interval timer
   // ----------------------------------------
   // One counter serves both intervals, which never overlap
   logic [OVPSEQ_CNT_W-1:0] cnt_r;
   logic [OVPSEQ_CNT_W-1:0] cnt_nxt;
   logic cnt_clr;
   logic start_done;
   logic blank_done;

   assign start_done = (cnt_r == START_LAST);
   assign blank_done = (cnt_r == BLANK_LAST);

   always_comb begin
      cnt_nxt = cnt_r;
      if (!rst_b_in) begin
         cnt_nxt = '0;
      end else if (ce_in) begin
         if (cnt_clr) begin
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      cnt_r <= cnt_nxt;
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   ovpseq_state_e state_r;
   ovpseq_state_e state_nxt;

   // Timer runs only while an interval is in progress; cleared otherwise
   always_comb begin
      state_nxt = state_r;
      cnt_clr = 1'b1;
      if (!rst_b_in) begin
         state_nxt = OVPSEQ_ST_LOCKOUT; // R11
      end else if (ce_in) begin
         if (!qualify) begin
            // Any loss of qualification drops back to the full delay
            state_nxt = OVPSEQ_ST_LOCKOUT; // R14
         end else begin
            unique case (state_r)
               OVPSEQ_ST_LOCKOUT: begin
                  state_nxt = OVPSEQ_ST_DELAY;
               end
               OVPSEQ_ST_DELAY: begin
                  if (start_done) begin
                     state_nxt = OVPSEQ_ST_STARTUP; // R9
                  end else begin
                     cnt_clr = 1'b0;
                  end
               end
               OVPSEQ_ST_STARTUP: begin
                  if (blank_done) begin
                     state_nxt = OVPSEQ_ST_ON; // R10
                  end else begin
                     cnt_clr = 1'b0;
                  end
               end
               OVPSEQ_ST_ON: begin
                  state_nxt = OVPSEQ_ST_ON;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in) begin
      state_r <= state_nxt;
   end

   // ----------------------------------------
   // Output drive
   // ----------------------------------------
   logic gate_r;
   logic gate_nxt;
   logic fault_oe_r;
   logic fault_oe_nxt;
   logic fault_lvl_r;
   logic fault_lvl_nxt;

   // Outputs follow the next state so they move with the state change itself
   always_comb begin
      gate_nxt = gate_r;
      fault_oe_nxt = fault_oe_r;
      // Open drain: the data level never leaves low
      fault_lvl_nxt = 1'b0; // R13
      if (!rst_b_in) begin
         gate_nxt = OVPSEQ_GATE_RST; // R11
         fault_oe_nxt = OVPSEQ_FAULT_OE_RST; // R11
      end else if (ce_in) begin
         unique case (state_nxt)
            OVPSEQ_ST_LOCKOUT: begin
               gate_nxt = 1'b0; // R3 R4 R5 R6 R12
               fault_oe_nxt = 1'b1; // R1 R5 R6 R7 R12
            end
            OVPSEQ_ST_DELAY: begin
               gate_nxt = 1'b0; // R9
               fault_oe_nxt = 1'b1; // R9
            end
            OVPSEQ_ST_STARTUP: begin
               gate_nxt = 1'b1; // R2 R10
               // Fault stays asserted through blanking
               fault_oe_nxt = 1'b1; // R8
            end
            OVPSEQ_ST_ON: begin
               gate_nxt = 1'b1; // R2
               fault_oe_nxt = 1'b0; // R1 R10
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      gate_r <= gate_nxt;
      fault_oe_r <= fault_oe_nxt;
      fault_lvl_r <= fault_lvl_nxt;
   end

   assign gate_out = gate_r;
   assign fault_b_out = fault_lvl_r; // R13
   assign fault_b_oe_out = fault_oe_r; // R13

endmodule

// >>> ovpseq_props.sv
`timescale 1ns/100ps
module ovpseq_props
   import ovpseq_pkg::*;
#(
   parameter int unsigned START_CYC = OVPSEQ_START_CYC,
   parameter int unsigned BLANK_CYC = OVPSEQ_BLANK_CYC
) (
   // Watched ports
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic low_supply_lockout_in,
   input wire logic high_supply_lockout_in,
   input wire logic enable_b_in,
   input wire logic gate_out,
   input wire logic fault_b_out,
   input wire logic fault_b_oe_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // ----------------
   // Run lengths
   // ----------------
   logic ok;
   int q_r, q_nxt, g_r, g_nxt;
   assign ok = !(low_supply_lockout_in | high_supply_lockout_in | enable_b_in);
   always_comb begin
      q_nxt = ok ? q_r + int'(ce_in) : 0;
      g_nxt = gate_out ? g_r + int'(ce_in) : 0;
   end
   always_ff @(posedge clk_in) begin
      q_r <= rst_b_in ? q_nxt : 0;
      g_r <= rst_b_in ? g_nxt : 0;
   end
   // ----------------
   // Properties
   // ----------------
   a_reset_outputs: assert property (disable iff (1'b0)
      !rst_b_in |=> !gate_out && fault_b_oe_out) else $error("bad reset outputs");
   a_low_forces_off: assert property (low_supply_lockout_in && ce_in ##1 ce_in [*2]
      |=> !gate_out && fault_b_oe_out) else $error("low lockout ignored");
   a_high_forces_off: assert property (high_supply_lockout_in && ce_in ##1 ce_in [*2]
      |=> !gate_out && fault_b_oe_out) else $error("high lockout ignored");
   a_enable_forces_off: assert property (enable_b_in && ce_in ##1 ce_in [*2]
      |=> !gate_out && fault_b_oe_out) else $error("enable high ignored");
   // Frozen clock enable holds the gate, so only judge after three live cycles
   a_gate_needs_ok: assert property (gate_out && $past(ce_in) && $past(ce_in, 2)
      && $past(ce_in, 3) |-> $past(ok, 3)) else $error("gate on outside window");
   a_start_min: assert property ($rose(gate_out) |-> q_r >= START_CYC)
      else $error("start delay short");
   a_start_max: assert property (q_r == START_CYC + 6 |-> gate_out)
      else $error("start delay long");
   a_blank_min: assert property ($fell(fault_b_oe_out) |-> g_r >= BLANK_CYC - 1)
      else $error("blanking short");
   a_open_drain: assert property (fault_b_oe_out |-> !fault_b_out)
      else $error("fault pin not low");
   c_gate_on: cover property ($rose(gate_out));
   c_flag_off: cover property ($fell(fault_b_oe_out));
   c_trip_on: cover property (gate_out && high_supply_lockout_in);
endmodule

bind ovpseq_top ovpseq_props #(.START_CYC(START_CYC), .BLANK_CYC(BLANK_CYC)) ovpseq_props_inst (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
   .low_supply_lockout_in(low_supply_lockout_in), .high_supply_lockout_in(high_supply_lockout_in),
   .enable_b_in(enable_b_in), .gate_out(gate_out), .fault_b_out(fault_b_out),
   .fault_b_oe_out(fault_b_oe_out));

// >>> ovpseq_host.sv
`timescale 1ns/100ps
module ovpseq_host (
   // Host side
   input wire logic clk_in,
   input wire logic off_req_in,
   output logic enable_b_out,
   // Fault pin
   input wire logic fault_b_in,
   input wire logic fault_b_oe_in,
   output logic flag_b_out
);
   // Pull-up wins when nobody sinks
   assign flag_b_out = fault_b_oe_in ? fault_b_in : 1'b1;
   // Host parks enable high until told to run
   initial enable_b_out = 1'b1;
   always @(posedge clk_in) begin
      enable_b_out <= off_req_in;
   end
endmodule

// >>> ovpseq_tb.sv
`timescale 1ns/100ps
module ovpseq_tb;
   import ovpseq_pkg::*;
   // ----------------
   // Short counts keep the run brief
   // ----------------
   localparam int SC = 20;
   localparam int BC = 30;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic ce_in = 1'b1;
   logic low_r = 1'b1;
   logic high_r = 1'b0;
   logic off_r = 1'b1;
   logic en_b, gate, fb, foe, flag_b;
   int fails = 0;
   int total_checks = 0;
   int n;
   ovpseq_top #(.START_CYC(SC), .BLANK_CYC(BC)) ovpseq_top_inst (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .ce_in(ce_in), .low_supply_lockout_in(low_r),
      .high_supply_lockout_in(high_r), .enable_b_in(en_b), .gate_out(gate),
      .fault_b_out(fb), .fault_b_oe_out(foe));
   ovpseq_host ovpseq_host_inst (.clk_in(clk_in), .off_req_in(off_r), .enable_b_out(en_b),
      .fault_b_in(fb), .fault_b_oe_in(foe), .flag_b_out(flag_b));
   initial forever #20 clk_in = ~clk_in;
   // ----------------
   // Tasks
   // ----------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t output mismatch", $time);
      end
   endtask
   function automatic logic win(input int c, input int lo, input int hi);
      return c >= lo && c <= hi;
   endfunction
   task automatic drive(input logic l, input logic h, input logic o, input int c);
      @(posedge clk_in);
      low_r <= l;
      high_r <= h;
      off_r <= o;
      repeat (c) @(negedge clk_in);
   endtask
   // Sampled on falling edges so design updates have landed
   task automatic wait_up(input logic pin, output int c);
      c = 0;
      while ((pin ? flag_b : gate) !== 1'b1 && c < 300) begin
         @(negedge clk_in);
         c++;
      end
      if (c >= 300) begin
         fails++;
         $display("BAD %0t wait timed out", $time);
         end_of_test();
      end
   endtask
   // ----------------
   // Sequence
   // ----------------
   initial begin
      void'($urandom(32'hD7A600E2));
      repeat (5) @(negedge clk_in);
      chk(gate, OVPSEQ_GATE_RST);
      chk(flag_b, !OVPSEQ_FAULT_OE_RST);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      drive(1'b1, 1'b0, 1'b0, 12);
      chk(gate, 1'b0);
      chk(flag_b, 1'b0);
      drive(1'b0, 1'b1, 1'b0, 12);
      chk(gate, 1'b0);
      chk(flag_b, 1'b0);
      drive(1'b0, 1'b0, 1'b0, 10);
      drive(1'b0, 1'b0, 1'b1, 3);
      for (int k = 0; k < 3; k++) begin
         drive(1'b0, 1'b0, 1'b0, 0);
         wait_up(1'b0, n);
         chk(win(n, SC + 2, SC + 7), 1'b1);
         chk(flag_b, 1'b0);
         if (k == 1) begin
            drive(1'b1, 1'b0, 1'b0, 5);
            chk(gate, 1'b0);
         end else begin
            wait_up(1'b1, n);
            chk(win(n, BC - 1, BC + 2), 1'b1);
            drive(1'b0, k == 0, k == 2, 5);
            chk(gate, 1'b0);
         end
         chk(flag_b, 1'b0);
      end
      repeat (60) begin
         drive($urandom % 4 == 0, $urandom % 4 == 0, $urandom % 4 == 0, int'(5 + $urandom % 60));
         if (low_r | high_r | off_r) begin
            chk(flag_b, 1'b0);
            chk(gate, 1'b0);
         end
      end
      // Reset in mid-run with the gate on, then a clean restart
      drive(1'b0, 1'b0, 1'b0, 0);
      wait_up(1'b0, n);
      wait_up(1'b1, n);
      @(posedge clk_in);
      rst_b_in <= 1'b0;
      repeat (3) @(negedge clk_in);
      chk(gate, OVPSEQ_GATE_RST);
      chk(flag_b, !OVPSEQ_FAULT_OE_RST);
      @(posedge clk_in);
      rst_b_in <= 1'b1;
      wait_up(1'b0, n);
      chk(win(n, SC + 2, SC + 7), 1'b1);
      wait_up(1'b1, n);
      chk(win(n, BC - 1, BC + 2), 1'b1);
      // Clock enable low freezes the outputs despite a trip
      @(posedge clk_in);
      ce_in <= 1'b0;
      high_r <= 1'b1;
      repeat (8) @(negedge clk_in);
      chk(gate, 1'b1);
      chk(flag_b, 1'b1);
      @(posedge clk_in);
      ce_in <= 1'b1;
      repeat (5) @(negedge clk_in);
      chk(gate, 1'b0);
      chk(flag_b, 1'b0);
      end_of_test();
   end
endmodule
